// ==== dv/fir_host_properties.sv ====
// Purpose: concurrent checks on the pins and user ports of the identification host
// Assumes: one core clock, reset asynchronous and active low
// Notes: bound into every fir_host instance
`timescale 1ns/1ns
module fir_host_properties
  import fir_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire logic data_valid_out,
  input wire logic [7:0] data_byte_out,
  input wire logic data_ready_in,
  input wire logic nand_ce_n_out,
  input wire logic nand_cle_out,
  input wire logic nand_ale_out,
  input wire logic nand_we_n_out,
  input wire logic nand_re_n_out,
  input wire logic [7:0] nand_io_out,
  input wire logic nand_io_oe_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // strobe counts per operation
  logic [1:0] op_q;
  logic [7:0] reads_q;
  logic [3:0] cmds_q;
  logic re_q;
  logic we_q;
  // count read strobes and command bytes since the last accept
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      op_q <= 2'h0;
      reads_q <= 8'h00;
      cmds_q <= 4'h0;
      re_q <= 1'b1;
      we_q <= 1'b1;
    end
    else
    begin
      re_q <= nand_re_n_out;
      we_q <= nand_we_n_out;
      if (req_valid_in && req_ready_out)
      begin
        op_q <= req_op_in;
        reads_q <= 8'h00;
        cmds_q <= 4'h0;
      end
      else
      begin
        if (re_q && !nand_re_n_out)
          reads_q <= reads_q + 8'h01;
        if (!we_q && nand_we_n_out && nand_cle_out)
          cmds_q <= cmds_q + 4'h1;
      end
    end
  end
  // ==========================================================
  // assertions
  a_accept_starts: assert property (req_valid_in && req_ready_out |=> !req_ready_out && !nand_ce_n_out)
    else $error("accepted request did not start");
  a_id_reads: assert property (done_out && op_q == OP_ID |-> reads_q == 8'h05 && cmds_q == 4'h1)
    else $error("id read strobe count wrong");
  a_sig_reads: assert property (done_out && op_q == OP_SIG |-> reads_q == 8'h04 && cmds_q == 4'h1)
    else $error("signature read strobe count wrong");
  a_uniq_cmds: assert property (done_out && op_q == OP_UNIQ |-> cmds_q == 4'h5 && reads_q >= 8'h21)
    else $error("identifier read command count wrong");
  a_write_shape: assert property ($fell(nand_we_n_out) |-> (nand_cle_out ^ nand_ale_out) && nand_io_oe_out
    ##1 (!nand_we_n_out && nand_io_oe_out && $stable(nand_io_out))[*3]
    ##1 (nand_we_n_out && nand_io_oe_out && $stable(nand_io_out))[*2])
    else $error("write strobe cycle malformed");
  a_read_quiet: assert property (!nand_re_n_out |-> !nand_io_oe_out && !nand_cle_out &&
    !nand_ale_out && !nand_ce_n_out)
    else $error("bus driven during read strobe");
  a_read_width: assert property ($fell(nand_re_n_out) |-> !nand_re_n_out[*7])
    else $error("read strobe too short");
  a_done_pulse: assert property (done_out |-> req_ready_out ##1 !done_out)
    else $error("done not a single pulse with ready");
  a_idle_quiet: assert property (req_ready_out && !done_out |-> nand_we_n_out && nand_re_n_out)
    else $error("strobe while idle");
  a_stream_hold: assert property (data_valid_out && !data_ready_in |=> data_valid_out &&
    $stable(data_byte_out))
    else $error("stalled byte changed or dropped");
endmodule

bind fir_host fir_host_properties i_fir_host_properties (.core_clk_in, .rst_n_in, .req_valid_in, .req_op_in,
  .req_ready_out, .done_out, .data_valid_out, .data_byte_out, .data_ready_in, .nand_ce_n_out, .nand_cle_out,
  .nand_ale_out, .nand_we_n_out, .nand_re_n_out, .nand_io_out, .nand_io_oe_out);

// ==== dv/fir_nand_model.sv ====
// Purpose: behavioural flash answering id, signature and unique identifier reads
// Assumes: strobes come from the host under test; the device has no clock
// Notes: a released data bus shows the inverse of the last byte
`timescale 1ns/1ns
module fir_nand_model #(
  parameter logic [39:0] ID_BYTES = 40'h5A3C909546, // maker and part codes arbitrary
  parameter logic [7:0] UNIQ_SEED = 8'h21
) (
  input wire logic ce_n_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic [7:0] io_in,
  input wire logic [3:0] busy_polls_in,
  input wire logic [4:0] bad_copy_in,
  input wire logic bad_sig_in,
  output logic [7:0] io_out
);
  localparam logic [31:0] SIG_BYTES = 32'h4F4E4649;
  logic [7:0] cmd_q = 8'hFF;
  logic [1:0] mode_q = 2'h0;
  logic [8:0] ptr_q = 9'h000;
  logic [8:0] col_q = 9'h000;
  logic [3:0] polls_q = 4'h0;
  logic [1:0] adr_q = 2'h0;
  logic [7:0] u;
  initial io_out = 8'hC3;
  // latch command and address bytes on the rising write strobe
  always @(posedge we_n_in)
  begin
    if (!ce_n_in && cle_in)
    begin
      cmd_q = io_in;
      adr_q = 2'h0;
      if (io_in == 8'h70)
        mode_q = 2'h3;
      if (io_in == 8'h70)
        polls_q = 4'h0;
      if (io_in == 8'h00 && mode_q == 2'h3)
        mode_q = 2'h2;
      if (io_in == 8'hE0)
        ptr_q = col_q;
    end
    if (!ce_n_in && ale_in)
    begin
      if (cmd_q == 8'h90)
        mode_q = (io_in == 8'h20) ? 2'h1 : 2'h0;
      if (cmd_q == 8'h90 || cmd_q == 8'hED)
        ptr_q = 9'h000;
      if (cmd_q == 8'hED)
        mode_q = 2'h2;
      if (cmd_q == 8'h05 && adr_q == 2'h0)
        col_q[7:0] = io_in;
      if (cmd_q == 8'h05 && adr_q == 2'h1)
        col_q[8] = io_in[0];
      adr_q = adr_q + 2'h1;
    end
  end
  // drive the addressed byte after the falling read strobe
  always @(negedge re_n_in)
  begin
    u = UNIQ_SEED + 8'h13 * {4'h0, ptr_q[3:0]};
    if (!ce_n_in)
      case (mode_q)
        2'h0: io_out = (ptr_q < 9'h005) ? ID_BYTES[39 - 8 * ptr_q -: 8] : ~ptr_q[7:0];
        2'h1: io_out = (ptr_q < 9'h004) ? SIG_BYTES[31 - 8 * ptr_q -: 8] ^ {7'h00, bad_sig_in && ptr_q == 9'h002}
          : 8'hA5 ^ ptr_q[7:0];
        2'h2: io_out = (ptr_q[4] ? ~u : u) ^ {7'h00, ptr_q[4] && bad_copy_in == {1'b0, ptr_q[8:5]}};
        default: io_out = (polls_q >= busy_polls_in) ? 8'hE0 : 8'h80;
      endcase
  end
  // release the bus and step to the next byte or poll
  always @(posedge re_n_in)
  begin
    io_out = ~io_out;
    if (mode_q == 2'h3)
      polls_q = polls_q + 4'h1;
    else
      ptr_q = ptr_q + 9'h001;
  end
endmodule

// ==== dv/tb_fir_host.sv ====
// Purpose: self-checking bench for the identification host
// Assumes: behavioural flash on the pin side
// Notes: stalls the byte stream so the two-entry buffer fills
`timescale 1ns/1ns
module tb_fir_host
  import fir_pkg::*;
;
  localparam logic [39:0] ID_EXP = 40'h5A3C909546; // maker and part codes arbitrary
  localparam logic [7:0] UNIQ_SEED = 8'h21;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic [1:0] req_op_in = 2'h0;
  logic [3:0] req_copy_in = 4'h0;
  logic data_ready_in = 1'b1;
  logic req_ready_out, done_out, sig_ok_out, uniq_ok_out, data_valid_out;
  logic nand_ce_n_out, nand_cle_out, nand_ale_out, nand_we_n_out, nand_re_n_out, nand_io_oe_out;
  logic [7:0] data_byte_out, nand_io_out, nand_io_in, dev_io;
  logic [3:0] busy_polls = 4'h0;
  logic [4:0] bad_copy = 5'h10;
  logic bad_sig = 1'b0;
  logic stall = 1'b0;
  logic [7:0] got[$];
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  // ==========================================================
  // design, flash model and bus wiring
  fir_host i_fir_host (.core_clk_in, .rst_n_in, .req_valid_in, .req_op_in, .req_copy_in, .req_ready_out, .done_out,
    .sig_ok_out, .uniq_ok_out, .data_valid_out, .data_byte_out, .data_ready_in, .nand_ce_n_out, .nand_cle_out,
    .nand_ale_out, .nand_we_n_out, .nand_re_n_out, .nand_io_out, .nand_io_oe_out, .nand_io_in);
  fir_nand_model #(.ID_BYTES(ID_EXP), .UNIQ_SEED(UNIQ_SEED)) i_fir_nand_model (.ce_n_in(nand_ce_n_out),
    .cle_in(nand_cle_out), .ale_in(nand_ale_out), .we_n_in(nand_we_n_out), .re_n_in(nand_re_n_out),
    .io_in(nand_io_out), .busy_polls_in(busy_polls), .bad_copy_in(bad_copy), .bad_sig_in(bad_sig), .io_out(dev_io));
  assign nand_io_in = nand_io_oe_out ? nand_io_out : dev_io;
  initial forever #4 core_clk_in = ~core_clk_in;
  // collect every byte the stream hands over
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (data_valid_out === 1'b1 && data_ready_in === 1'b1)
      got.push_back(data_byte_out);
  end
  // ==========================================================
  // shared tasks
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e, input string what);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t %s is %b", $time, what, g);
    end
  endtask
  task automatic run_op(input logic [1:0] op, input logic [3:0] copy);
    int n;
    got.delete();
    n = 0;
    while (req_ready_out !== 1'b1 && n < 100)
    begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    req_op_in = op;
    req_copy_in = copy;
    req_valid_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    req_valid_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 20000)
    begin
      @(posedge core_clk_in);
      #1;
      data_ready_in = stall ? (cyc % 40 < 4) : 1'b1;
      n++;
    end
    cmp1(done_out, 1'b1, "done");
    data_ready_in = 1'b1;
    repeat (8) @(posedge core_clk_in);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_id_read;
    stall = 1'b1;
    repeat (2)
    begin
      run_op(OP_ID, 4'h0);
      cmp1(got.size() == 5, 1'b1, "id byte count");
      for (int i = 0; i < 5; i++)
        cmp8(got[i], ID_EXP[39 - 8 * i -: 8]);
      cmp1(got[4][6:4] == 3'h4, 1'b1, "fifth byte fixed field");
    end
  endtask
  task automatic t_sig_read;
    for (int b = 0; b < 2; b++)
    begin
      bad_sig = b[0];
      run_op(OP_SIG, 4'h0);
      cmp1(got.size() == 4, 1'b1, "signature count");
      cmp1(sig_ok_out, b == 0, "signature ok");
      cmp8(got[0], 8'h4F);
      cmp8(got[3], 8'h49);
    end
    bad_sig = 1'b0;
  endtask
  task automatic t_uniq_read;
    logic [3:0] copies[4] = '{4'h0, 4'h1, 4'hF, 4'h5};
    logic [7:0] e;
    for (int k = 0; k < 4; k++)
    begin
      busy_polls = (k == 1) ? 4'h3 : 4'h0;
      bad_copy = (k == 3) ? 5'h05 : 5'h10;
      run_op(OP_UNIQ, copies[k]);
      cmp1(got.size() == 32, 1'b1, "identifier count");
      for (int i = 0; i < 32; i++)
      begin
        e = UNIQ_SEED + 8'h13 * {4'h0, i[3:0]};
        e = (i >= 16) ? ~e ^ {7'h00, k == 3} : e;
        cmp8(got[i], e);
      end
      cmp1(uniq_ok_out, k != 3, "identifier ok");
    end
    bad_copy = 5'h10;
  endtask
  task automatic t_noop;
    run_op(2'h3, 4'h0);
    cmp1(got.size() == 0, 1'b1, "no-op bytes");
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // cut a hang short; the full sequence needs far less
  initial
  begin
    #600000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
  // reset, then run every scenario
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    #1;
    rst_n_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    t_id_read();
    t_sig_read();
    t_uniq_read();
    t_noop();
    conclude();
  end
endmodule

// ==== rtl/fir_fifo.sv ====
// Purpose: small shift buffer with valid and ready on both sides
// Assumes: single clock, push and pop from logic on that clock
// Notes: all outputs come straight from flip-flops
`timescale 1ns/1ns
module fir_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [DEPTH-1:0] val_q;
  logic [DEPTH-1:0] val_d;

  // ==========================================================
  // next contents: pop shifts down, push fills first free slot
  always_comb
  begin
    logic placed;
    placed = 1'b0;
    mem_d = mem_q;
    val_d = val_q;
    if (val_q[0] && out_ready_in)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        mem_d[i] = mem_q[i + 1];
        val_d[i] = val_q[i + 1];
      end
      val_d[DEPTH-1] = 1'b0;
    end
    if (in_valid_in && !val_q[DEPTH-1])
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (!placed && !val_d[i])
        begin
          mem_d[i] = in_data_in;
          val_d[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end

  // registers
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      val_q <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
    end
    else
    begin
      val_q <= val_d;
      mem_q <= mem_d;
    end
  end

  assign in_ready_out = !val_q[DEPTH-1]; // full when last slot holds a word
  assign out_valid_out = val_q[0];
  assign out_data_out = mem_q[0];

endmodule

// ==== rtl/fir_host.sv ====
// Purpose: host controller that runs identification, signature and unique identifier reads on a flash
// Assumes: flash bus pins driven from the core clock; data pins are asynchronous inputs
// Notes: read bytes pass a two-entry buffer so a stalled consumer pauses the read strobes
`timescale 1ns/1ns
// Overview of operation
// [RULE1] the identification read is a 90H command followed by one 00H address cycle.
// [RULE2] the identification read strobes out five bytes in order: maker, part code, then three characteristic bytes.
// [RULE3] the flash stays in identification read mode until the next command, so no exit cycle is sent.
// [RULE4] the third byte carries die count, cell levels, simultaneous pages, interleave and cache flags.
// [RULE5] the fourth byte carries page size, spare size and block size fields.
// [RULE6] the fourth byte also carries bus width and the serial access time, 25 ns or 20 ns.
// [RULE7] the fifth byte carries correction level, plane count, a fixed 100 field and the internal correction flag.
// [RULE8] the signature read is 90H with address 20H and returns 4FH, 4EH, 46H, 49H.
// [RULE9] only four signature bytes are strobed, since later bytes are undefined.
// [RULE10] the unique identifier read starts with command EDH and yields a 16-byte identifier.
// [RULE11] each identifier copy is followed by its complement and is valid only if their XOR is all ones.
// [RULE12] the identifier area is sixteen 32-byte records, so copy n starts at byte offset 32 times n.
// [RULE13] the output position is moved with the 05H, column, E0H sequence.
// [RULE14] completion of the identifier read is checked by polling status with 70H.
// [RULE15] after the status poll a 00H command re-enables identifier data output.
// [RULE16] bytes latch on the rising write strobe with a latch enable high; data follows each falling read strobe.
module fir_host
  import fir_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic [3:0] req_copy_in,
  output logic req_ready_out,
  output logic done_out,
  output logic sig_ok_out,
  output logic uniq_ok_out,
  output logic data_valid_out,
  output logic [7:0] data_byte_out,
  input wire logic data_ready_in,
  output logic nand_ce_n_out,
  output logic nand_cle_out,
  output logic nand_ale_out,
  output logic nand_we_n_out,
  output logic nand_re_n_out,
  output logic [7:0] nand_io_out,
  output logic nand_io_oe_out,
  input wire logic [7:0] nand_io_in
);

  typedef enum {FIR_S_IDLE, FIR_S_GATE, FIR_S_LO, FIR_S_HI} fir_state_t;

  // ==========================================================
  // step table per operation
  function automatic fir_step_t get_step(input logic [1:0] op, input logic [3:0] idx, input logic [8:0] col);
    fir_step_t s;
    s.kind = FIR_K_END;
    s.data = 8'h00;
    if (op == OP_ID || op == OP_SIG)
    begin
      unique case (idx)
        4'h0: s = '{FIR_K_CMD, CMD_READ_ID}; // [RULE1] [RULE8]
        4'h1: s = '{FIR_K_ADR, (op == OP_ID) ? ADR_ID : ADR_SIG}; // [RULE1] [RULE8]
        4'h2: s = '{FIR_K_WAIT, 8'h00};
        4'h3: s = '{FIR_K_RD, 8'h00}; // [RULE3]
        default: s = '{FIR_K_END, 8'h00};
      endcase
    end
    else if (op == OP_UNIQ)
    begin
      unique case (idx)
        4'h0: s = '{FIR_K_CMD, CMD_UNIQUE_ID}; // [RULE10]
        4'h1: s = '{FIR_K_ADR, ADR_UNIQUE_ID};
        4'h2: s = '{FIR_K_WAIT, 8'h00};
        4'h3: s = '{FIR_K_CMD, CMD_STATUS}; // [RULE14]
        4'h4: s = '{FIR_K_WAIT, 8'h00};
        4'h5: s = '{FIR_K_POLL, 8'h00}; // [RULE14]
        4'h6: s = '{FIR_K_CMD, CMD_READ_MODE}; // [RULE15]
        4'h7: s = '{FIR_K_CMD, CMD_RAND_OUT}; // [RULE13]
        4'h8: s = '{FIR_K_ADR, col[7:0]}; // [RULE13] [RULE12]
        4'h9: s = '{FIR_K_ADR, {7'h00, col[8]}}; // [RULE13]
        4'hA: s = '{FIR_K_CMD, CMD_RAND_CONF}; // [RULE13]
        4'hB: s = '{FIR_K_WAIT, 8'h00};
        4'hC: s = '{FIR_K_RD, 8'h00};
        default: s = '{FIR_K_END, 8'h00};
      endcase
    end
    return s;
  endfunction

  fir_state_t state_q, state_d;
  logic [3:0] step_q, step_d;
  logic [7:0] tmr_q, tmr_d;
  logic [1:0] op_q, op_d;
  logic [8:0] col_q, col_d;
  logic [5:0] rcnt_q, rcnt_d;
  logic [5:0] bidx_q, bidx_d;
  logic [7:0] uniq_mem_q [UNIQ_BYTES];
  logic [7:0] uniq_mem_d [UNIQ_BYTES];
  logic ready_q, ready_d, done_q, done_d, sig_ok_q, sig_ok_d, uniq_ok_q, uniq_ok_d;
  logic ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d, oe_q, oe_d;
  logic [7:0] io_q, io_d, io_s1_q, io_s2_q, io_s3_q, smp_q, smp_d;
  logic push, buf_ready, io_stable;
  fir_step_t cur, nxt;

  // ==========================================================
  // pin synchroniser for the data bus
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      io_s3_q <= 8'h00;
    end
    else
    begin
      io_s1_q <= nand_io_in;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
    end
  end

  assign io_stable = (io_s2_q == io_s3_q); // settled once last two stages agree

  // ==========================================================
  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    step_d = step_q;
    tmr_d = tmr_q + 8'h01;
    op_d = op_q;
    col_d = col_q;
    rcnt_d = rcnt_q;
    bidx_d = bidx_q;
    uniq_mem_d = uniq_mem_q;
    ready_d = 1'b0;
    done_d = 1'b0;
    sig_ok_d = sig_ok_q;
    uniq_ok_d = uniq_ok_q;
    smp_d = smp_q;
    push = 1'b0;
    cur = get_step(op_q, step_q, col_q);
    unique case (state_q)
      FIR_S_IDLE:
      begin
        ready_d = 1'b1;
        tmr_d = 8'h00;
        if (req_valid_in && ready_q)
        begin
          ready_d = 1'b0;
          op_d = req_op_in;
          col_d = {req_copy_in, 5'h00}; // [RULE12]
          rcnt_d = (req_op_in == OP_UNIQ) ? UNIQ_REC_LEN
            : ((req_op_in == OP_SIG) ? SIG_LEN : ID_LEN); // [RULE2] [RULE9]
          bidx_d = 6'h00;
          step_d = 4'h0;
          sig_ok_d = 1'b0;
          uniq_ok_d = 1'b0;
          state_d = FIR_S_GATE;
        end
      end
      FIR_S_GATE:
      begin
        tmr_d = 8'h00;
        if (cur.kind == FIR_K_END)
        begin
          done_d = 1'b1;
          ready_d = 1'b1;
          state_d = FIR_S_IDLE;
        end
        else if (cur.kind != FIR_K_RD || buf_ready)
        begin
          state_d = FIR_S_LO; // read strobe waits for buffer room
        end
      end
      FIR_S_LO:
      begin
        if (cur.kind == FIR_K_CMD || cur.kind == FIR_K_ADR)
        begin
          if (tmr_q == 8'(WE_LOW_CYC - 1))
          begin
            tmr_d = 8'h00;
            state_d = FIR_S_HI;
          end
        end
        else if (cur.kind == FIR_K_WAIT)
        begin
          if (tmr_q == 8'(TURN_WAIT_CYC - 1))
          begin
            step_d = step_q + 4'h1;
            state_d = FIR_S_GATE;
          end
        end
        else if (tmr_q >= 8'(RD_LOW_CYC - 1) && io_stable)
        begin
          tmr_d = 8'h00;
          smp_d = io_s3_q; // [RULE16]
          state_d = FIR_S_HI;
          if (cur.kind == FIR_K_RD)
          begin
            push = 1'b1; // bytes pass raw, fields decoded by the user [RULE4] [RULE5] [RULE6] [RULE7]
            bidx_d = bidx_q + 6'h01;
            if (op_q == OP_SIG && bidx_q < 6'(SIG_LEN))
            begin
              // one bad byte anywhere keeps the flag low to the end
              sig_ok_d = (bidx_q == 6'h00 || sig_ok_q) && (smp_d == SIG_WORD[8'(31 - 8 * bidx_q) -: 8]); // [RULE8]
            end
            if (op_q == OP_UNIQ && bidx_q < 6'(UNIQ_BYTES))
            begin
              uniq_mem_d[bidx_q[3:0]] = smp_d;
            end
            else if (op_q == OP_UNIQ)
            begin
              uniq_ok_d = (bidx_q == 6'(UNIQ_BYTES) || uniq_ok_q)
                && ((uniq_mem_q[bidx_q[3:0]] ^ smp_d) == 8'hFF); // [RULE11]
            end
          end
        end
      end
      FIR_S_HI:
      begin
        if ((cur.kind == FIR_K_CMD || cur.kind == FIR_K_ADR) && tmr_q == 8'(WE_HIGH_CYC - 1))
        begin
          step_d = step_q + 4'h1;
          state_d = FIR_S_GATE;
        end
        else if ((cur.kind == FIR_K_RD || cur.kind == FIR_K_POLL) && tmr_q == 8'(RE_HIGH_CYC - 1))
        begin
          state_d = FIR_S_GATE;
          if (cur.kind == FIR_K_POLL && smp_q[STATUS_READY_BIT])
          begin
            step_d = step_q + 4'h1; // [RULE14]
          end
          else if (cur.kind == FIR_K_RD)
          begin
            rcnt_d = rcnt_q - 6'h01;
            if (rcnt_q == 6'h01)
            begin
              step_d = step_q + 4'h1; // stop after the last byte [RULE9]
            end
          end
        end
      end
    endcase
    // pin levels follow the state being entered
    nxt = get_step(op_d, step_d, col_d);
    ce_n_d = (state_d == FIR_S_IDLE);
    cle_d = (nxt.kind == FIR_K_CMD) && (state_d == FIR_S_LO || state_d == FIR_S_HI); // [RULE16]
    ale_d = (nxt.kind == FIR_K_ADR) && (state_d == FIR_S_LO || state_d == FIR_S_HI); // [RULE16]
    oe_d = cle_d || ale_d;
    io_d = oe_d ? nxt.data : 8'h00;
    we_n_d = !(oe_d && state_d == FIR_S_LO); // rising edge latches the byte [RULE16]
    re_n_d = !((nxt.kind == FIR_K_RD || nxt.kind == FIR_K_POLL) && state_d == FIR_S_LO); // [RULE16]
  end

  // sequencer registers
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= FIR_S_IDLE;
      step_q <= 4'h0;
      tmr_q <= 8'h00;
      op_q <= 2'h0;
      col_q <= 9'h000;
      rcnt_q <= 6'h00;
      bidx_q <= 6'h00;
      for (int i = 0; i < UNIQ_BYTES; i++)
      begin
        uniq_mem_q[i] <= 8'h00;
      end
      ready_q <= 1'b0;
      done_q <= 1'b0;
      sig_ok_q <= 1'b0;
      uniq_ok_q <= 1'b0;
      smp_q <= 8'h00;
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      oe_q <= 1'b0;
      io_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      step_q <= step_d;
      tmr_q <= tmr_d;
      op_q <= op_d;
      col_q <= col_d;
      rcnt_q <= rcnt_d;
      bidx_q <= bidx_d;
      uniq_mem_q <= uniq_mem_d;
      ready_q <= ready_d;
      done_q <= done_d;
      sig_ok_q <= sig_ok_d;
      uniq_ok_q <= uniq_ok_d;
      smp_q <= smp_d;
      ce_n_q <= ce_n_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      oe_q <= oe_d;
      io_q <= io_d;
    end
  end

  // ==========================================================
  // read data buffer toward the user
  fir_fifo #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push),
    .in_data_in(smp_d),
    .in_ready_out(buf_ready),
    .out_valid_out(data_valid_out),
    .out_data_out(data_byte_out),
    .out_ready_in(data_ready_in)
  );

  // registered outputs
  assign req_ready_out = ready_q;
  assign done_out = done_q;
  assign sig_ok_out = sig_ok_q;
  assign uniq_ok_out = uniq_ok_q;
  assign nand_ce_n_out = ce_n_q;
  assign nand_cle_out = cle_q;
  assign nand_ale_out = ale_q;
  assign nand_we_n_out = we_n_q;
  assign nand_re_n_out = re_n_q;
  assign nand_io_out = io_q;
  assign nand_io_oe_out = oe_q;

endmodule

// ==== rtl/fir_pkg.sv ====
// Purpose: shared constants and types for the flash identification readout host
// Assumes: 125 MHz core clock, 8-bit flash bus
// Notes: times are in ns; cycle counts are derived from them
package fir_pkg;

  // ==========================================================
  // clock and pin timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WE_LOW_NS = 25; // write strobe low time
  localparam int unsigned WE_HIGH_NS = 15; // write strobe high time
  localparam int unsigned RD_ACCESS_NS = 25; // read strobe to data valid
  localparam int unsigned RE_HIGH_NS = 15; // read strobe high time
  localparam int unsigned TURN_WAIT_NS = 100; // busy onset and write-to-read turnaround
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RD_LOW_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int unsigned RE_HIGH_CYC = (RE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TURN_WAIT_CYC = (TURN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // command and address bytes
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] ADR_ID = 8'h00;
  localparam logic [7:0] ADR_SIG = 8'h20;
  localparam logic [7:0] CMD_UNIQUE_ID = 8'hED;
  localparam logic [7:0] ADR_UNIQUE_ID = 8'h00;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_RAND_OUT = 8'h05;
  localparam logic [7:0] CMD_RAND_CONF = 8'hE0;
  localparam int unsigned STATUS_READY_BIT = 6;

  // ==========================================================
  // read lengths and expected data
  localparam logic [5:0] ID_LEN = 6'h05;
  localparam logic [5:0] SIG_LEN = 6'h04;
  localparam int unsigned UNIQ_BYTES = 16;
  localparam logic [5:0] UNIQ_REC_LEN = 6'h20; // identifier plus complement
  localparam logic [31:0] SIG_WORD = 32'h4F4E4649; // first byte in the top lane

  // ==========================================================
  // user operations and sequence steps
  localparam logic [1:0] OP_ID = 2'h0;
  localparam logic [1:0] OP_SIG = 2'h1;
  localparam logic [1:0] OP_UNIQ = 2'h2;

  typedef enum {FIR_K_CMD, FIR_K_ADR, FIR_K_WAIT, FIR_K_RD, FIR_K_POLL, FIR_K_END} fir_kind_t;

  typedef struct packed {
    fir_kind_t kind;
    logic [7:0] data;
  } fir_step_t;

endpackage
